// ==== verilog/hadag_glue.sv ====
/*
 * Host address decoder with registered selects and acknowledge stage.
 * Assumes host pins are asynchronous to clk_in; each passes two
 * flip-flops first, so select outputs lag the pins by three clock edges.
 */
`timescale 1ns/10ps
module hadag_glue
	import hadag_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic address_strobe_n_in,
	input wire logic data_strobe_n_in,
	input wire logic read_write_in,
	input wire logic [HADAG_ADDR_W-1:0] addr_in,
	input wire logic own0_n_in,
	input wire logic own1_n_in,
	output logic rom_select_n_out,
	output logic ram_select_n_out,
	output logic link_ctrl_select_n_out,
	output logic link_ctrl_int_ack_n_out,
	output logic uart_periph_select_n_out,
	output logic ram_write_n_out,
	output logic ram_output_n_out,
	output logic autovector_request_n_out,
	output logic rom_ack_normal_n_out,
	output logic rom_ack_normal_oe_out,
	output logic rom_ack_delayed_n_out,
	output logic rom_ack_delayed_oe_out,
	output logic ram_ack_n_out,
	output logic ram_ack_oe_out
);
	localparam int SYNC_W = 10;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic rom_n;
		logic ram_n;
		logic link_n;
		logic iack_n;
		logic uart_n;
		logic we_n;
		logic oe_n;
		logic vpa_n;
	} hadag_dec_state_t;

	hadag_dec_state_t state_reg;
	hadag_dec_state_t state_next;
	logic [SYNC_W-1:0] pins;
	logic as_act, ds_act, rw_rd, a2, a14, a15, a16, a17, own0, own1;
	logic ram_page;

	// Only address bits the decoder reads are synchronised
	assign pins = {address_strobe_n_in, data_strobe_n_in, read_write_in,
		addr_in[HADAG_BIT_A2], addr_in[HADAG_BIT_A14], addr_in[HADAG_BIT_A15],
		addr_in[HADAG_BIT_A16], addr_in[HADAG_BIT_A17], own1_n_in, own0_n_in};

	// Second stage only; the first stage feeds nothing else
	assign as_act = ~state_reg.sync2[9];
	assign ds_act = ~state_reg.sync2[8];
	assign rw_rd = state_reg.sync2[7];
	assign a2 = state_reg.sync2[6];
	assign a14 = state_reg.sync2[5];
	assign a15 = state_reg.sync2[4];
	assign a16 = state_reg.sync2[3];
	assign a17 = state_reg.sync2[2];
	assign own1 = state_reg.sync2[1];
	assign own0 = state_reg.sync2[0];

	// RAM page: host page or DMA with exactly one ownership pin low
	// Partial decode: A14 and A17 ignored here, hence the alias page
	assign ram_page = (a16 & ~a15 & own0 & own1)
		| (~a15 & (own0 ^ own1));

	// All selects active low, formed from the same synchronised sample
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = pins;
		state_next.sync2 = state_reg.sync1;
		state_next.rom_n = ~(as_act & ~a16);
		state_next.uart_n = ~(as_act & a16 & a15 & a14);
		state_next.link_n = ~(as_act & a16 & a15 & ~a14);
		state_next.ram_n = ~(as_act & ram_page);
		// A17 alone marks the vector fetch; function codes unused
		state_next.iack_n = ~(as_act & a17 & a2);
		state_next.vpa_n = ~(as_act & a17 & ~a2);
		state_next.we_n = ~(ds_act & ~rw_rd & as_act & ram_page);
		state_next.oe_n = ~(ds_act & rw_rd & as_act & ram_page);
	end

	// Strobes idle inactive so no select glitches out of reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= '{sync1: {SYNC_W{1'b1}}, sync2: {SYNC_W{1'b1}},
				rom_n: HADAG_INACTIVE, ram_n: HADAG_INACTIVE,
				link_n: HADAG_INACTIVE, iack_n: HADAG_INACTIVE,
				uart_n: HADAG_INACTIVE, we_n: HADAG_INACTIVE,
				oe_n: HADAG_INACTIVE, vpa_n: HADAG_INACTIVE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rom_select_n_out = state_reg.rom_n;
	assign ram_select_n_out = state_reg.ram_n;
	assign link_ctrl_select_n_out = state_reg.link_n;
	assign link_ctrl_int_ack_n_out = state_reg.iack_n;
	assign uart_periph_select_n_out = state_reg.uart_n;
	assign ram_write_n_out = state_reg.we_n;
	assign ram_output_n_out = state_reg.oe_n;
	assign autovector_request_n_out = state_reg.vpa_n;

	// Acknowledge stage fed by registered selects
	hadag_ack_gen u_ack (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.rom_sel_in(~state_reg.rom_n),
		.ram_sel_in(~state_reg.ram_n),
		.rom_ack_normal_n_out(rom_ack_normal_n_out),
		.rom_ack_normal_oe_out(rom_ack_normal_oe_out),
		.rom_ack_delayed_n_out(rom_ack_delayed_n_out),
		.rom_ack_delayed_oe_out(rom_ack_delayed_oe_out),
		.ram_ack_n_out(ram_ack_n_out),
		.ram_ack_oe_out(ram_ack_oe_out)
	);
endmodule

// ==== common/hadag_pkg.sv ====
/*
 * Constants for the host address decode and acknowledge glue.
 * Assumes a single 20 MHz system clock and active-low bus strobes.
 */
// Function
// - Four ROM pages, one each for others
// - UART and link selects from A16-A14
// - Incomplete decode leaves alias pages
// - A17 high marks interrupt vector fetch
// - Fetch with A2 high acknowledges link
// - Fetch with A2 low requests autovector
// - Three-stage ROM wait chain on clock
// - Normal and delayed ROM acknowledges
// - RAM acknowledge follows RAM select
// - Acknowledges float while own select idle
// - RAM select by page or DMA ownership
// - RAM write enable on strobed write
// - RAM output enable on strobed read
package hadag_pkg;
	// Address bit positions within the 18-bit host address
	localparam int HADAG_ADDR_W = 18;
	localparam int HADAG_BIT_A2 = 2;
	localparam int HADAG_BIT_A14 = 14;
	localparam int HADAG_BIT_A15 = 15;
	localparam int HADAG_BIT_A16 = 16;
	localparam int HADAG_BIT_A17 = 17;
	// Page size in bytes
	localparam int HADAG_PAGE_BYTES = 16384;
	// Reset value of the wait chain
	localparam logic [2:0] HADAG_CHAIN_RST = 3'h0;
	// Reset value of the inactive strobes
	localparam logic HADAG_INACTIVE = 1'b1;
endpackage

// ==== verilog/hadag_ack_gen.sv ====
/*
 * ROM and RAM acknowledge generator with a registered wait chain.
 * Assumes selects arrive already synchronised to clk_in.
 */
`timescale 1ns/10ps
module hadag_ack_gen
	import hadag_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic rom_sel_in,
	input wire logic ram_sel_in,
	output logic rom_ack_normal_n_out,
	output logic rom_ack_normal_oe_out,
	output logic rom_ack_delayed_n_out,
	output logic rom_ack_delayed_oe_out,
	output logic ram_ack_n_out,
	output logic ram_ack_oe_out
);
	typedef struct packed {
		logic [2:0] wait_stage;
		logic ack_normal_n;
		logic ack_delayed_n;
		logic ram_ack_n;
		logic rom_oe;
		logic ram_oe;
	} hadag_ack_state_t;

	hadag_ack_state_t state_reg;
	hadag_ack_state_t state_next;

	// Chain shifts in while select holds; a dropped select clears it
	always_comb begin
		state_next = state_reg;
		state_next.wait_stage[0] = rom_sel_in;
		state_next.wait_stage[1] = rom_sel_in & state_reg.wait_stage[0];
		state_next.wait_stage[2] = rom_sel_in & state_reg.wait_stage[0]
			& state_reg.wait_stage[1];
		// Acknowledges taken from the updated chain so outputs stay registered
		state_next.ack_normal_n = ~(state_next.wait_stage[0] & state_next.wait_stage[1]
			& rom_sel_in);
		state_next.ack_delayed_n = ~(state_next.wait_stage[1] & state_next.wait_stage[2]
			& rom_sel_in);
		state_next.ram_ack_n = ~ram_sel_in;
		state_next.rom_oe = rom_sel_in;
		state_next.ram_oe = ram_sel_in;
	end

	// Acknowledges idle high and undriven after reset
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= '{wait_stage: HADAG_CHAIN_RST, ack_normal_n: HADAG_INACTIVE,
				ack_delayed_n: HADAG_INACTIVE, ram_ack_n: HADAG_INACTIVE,
				rom_oe: 1'b0, ram_oe: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rom_ack_normal_n_out = state_reg.ack_normal_n;
	assign rom_ack_normal_oe_out = state_reg.rom_oe;
	assign rom_ack_delayed_n_out = state_reg.ack_delayed_n;
	assign rom_ack_delayed_oe_out = state_reg.rom_oe;
	assign ram_ack_n_out = state_reg.ram_ack_n;
	assign ram_ack_oe_out = state_reg.ram_oe;
endmodule

// ==== testbench/hadag_glue_properties.sv ====
/* Timing checker for hadag_glue, bound to its ports.
   Assumes pins idle in reset; decode lags pins three edges. */
`timescale 1ns/10ps
module hadag_glue_properties
	import hadag_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic address_strobe_n_in,
	input wire logic [HADAG_ADDR_W-1:0] addr_in,
	input wire logic own0_n_in,
	input wire logic own1_n_in,
	input wire logic rom_select_n_out,
	input wire logic ram_select_n_out,
	input wire logic link_ctrl_select_n_out,
	input wire logic link_ctrl_int_ack_n_out,
	input wire logic uart_periph_select_n_out,
	input wire logic autovector_request_n_out,
	input wire logic rom_ack_normal_n_out,
	input wire logic rom_ack_normal_oe_out,
	input wire logic rom_ack_delayed_n_out,
	input wire logic rom_ack_delayed_oe_out,
	input wire logic ram_ack_n_out,
	input wire logic ram_ack_oe_out
);
	logic [2:0] run_reg;
	logic [7:0] p1, p2, p3;
	// Settle count, so no check looks back into reset
	always_ff @(posedge clk_in) begin
		if (srst_in)
			run_reg <= 3'h0;
		else if (!run_reg[2])
			run_reg <= run_reg + 3'h1;
	end
	// Pins three samples back: {strobe, A17..A14, A2, own1, own0}
	always_ff @(posedge clk_in) begin
		p1 <= {address_strobe_n_in, addr_in[17:14], addr_in[2], own1_n_in, own0_n_in};
		p2 <= p1;
		p3 <= p2;
	end
	wire act = !p3[7];
	wire ram = act & !p3[4] & ((p3[5] & p3[1:0] == 2'h3) | ^p3[1:0]);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	a_rom_select: assert property (run_reg[2] |-> !rom_select_n_out == (act & !p3[5]))
		else $error("rom select wrong");
	a_periph_select: assert property (run_reg[2] |->
		{!uart_periph_select_n_out, !link_ctrl_select_n_out} == {act & (&p3[5:3]),
		act & p3[5] & p3[4] & !p3[3]}) else $error("peripheral select wrong");
	a_link_iack: assert property (run_reg[2] |-> !link_ctrl_int_ack_n_out == (act & p3[6] & p3[2]))
		else $error("link acknowledge wrong");
	a_autovec_req: assert property (run_reg[2] |-> !autovector_request_n_out == (act & p3[6] & !p3[2]))
		else $error("autovector request wrong");
	a_ram_select: assert property (run_reg[2] |-> !ram_select_n_out == ram)
		else $error("ram select wrong");
	a_ram_ack: assert property (run_reg[2] |-> ram_ack_oe_out == !$past(ram_select_n_out)
		&& (!ram_ack_oe_out || !ram_ack_n_out)) else $error("ram acknowledge wrong");
	a_rom_ack_normal: assert property (run_reg[2] |-> rom_ack_normal_oe_out == !$past(rom_select_n_out)
		&& (rom_ack_normal_oe_out && !rom_ack_normal_n_out) == !($past(rom_select_n_out)
		| $past(rom_select_n_out, 2))) else $error("normal rom acknowledge wrong");
	a_rom_ack_delayed: assert property (run_reg[2] |-> rom_ack_delayed_oe_out == !$past(rom_select_n_out)
		&& (rom_ack_delayed_oe_out && !rom_ack_delayed_n_out) == !($past(rom_select_n_out)
		| $past(rom_select_n_out, 2) | $past(rom_select_n_out, 3))) else $error("delayed rom acknowledge wrong");
endmodule

bind hadag_glue hadag_glue_properties hadag_glue_properties_i (.*);

// ==== testbench/hadag_far_model.sv ====
/* Far side: pulled-up acknowledge wires and link controller ownership.
   Assumes the bench supplies the DMA grants. */
`timescale 1ns/10ps
module hadag_far_model (
	input wire logic [1:0] grant_in,
	input wire logic [2:0] ack_n_in,
	input wire logic [2:0] ack_oe_in,
	output logic [1:0] own_n_out,
	output logic [2:0] ack_line_out
);
	// Ownership pins low only while that channel masters the bus
	assign own_n_out = ~grant_in;
	// A released wire rises to its pull-up, never keeps the last value
	assign ack_line_out = ack_n_in | ~ack_oe_in;
endmodule

// ==== testbench/hadag_glue_test.sv ====
/* Bench for hadag_glue: decode table, DMA paging, ack timing.
   Assumes three-edge decode lag and pulled-up ack wires. */
`timescale 1ns/10ps
module hadag_glue_test;
	logic clk_in = 0, srst_in = 1, as_n = 1, ds_n = 1, rw = 1;
	logic [17:0] addr = 18'h0_0000;
	logic [1:0] grant = 2'h0, own_n;
	logic [2:0] line, an, ao;
	logic [7:0] dec;
	int mismatches = 0, tests_run = 0;
	hadag_glue hadag_glue_i (.clk_in(clk_in), .srst_in(srst_in), .address_strobe_n_in(as_n),
		.data_strobe_n_in(ds_n), .read_write_in(rw), .addr_in(addr), .own0_n_in(own_n[0]),
		.own1_n_in(own_n[1]), .rom_select_n_out(dec[7]), .ram_select_n_out(dec[6]),
		.link_ctrl_select_n_out(dec[5]), .link_ctrl_int_ack_n_out(dec[4]),
		.uart_periph_select_n_out(dec[3]), .ram_write_n_out(dec[2]), .ram_output_n_out(dec[1]),
		.autovector_request_n_out(dec[0]), .rom_ack_normal_n_out(an[0]),
		.rom_ack_normal_oe_out(ao[0]), .rom_ack_delayed_n_out(an[1]),
		.rom_ack_delayed_oe_out(ao[1]), .ram_ack_n_out(an[2]), .ram_ack_oe_out(ao[2]));
	hadag_far_model hadag_far_model_i (.grant_in(grant), .ack_n_in(an), .ack_oe_in(ao),
		.own_n_out(own_n), .ack_line_out(line));
	initial forever #25 clk_in = !clk_in;
	// Active-low {rom, ram, link, iack, uart, write, read, autovector}
	function automatic logic [7:0] expect_dec(input logic [17:0] a, input logic r, input logic [1:0] g);
		logic m;
		m = !a[15] & ((a[16] & (g == 2'h0)) | ^g);
		return ~{!a[16], m, a[16] & a[15] & !a[14], a[17] & a[2], a[16] & a[15] & a[14],
			m & !r, m & r, a[17] & !a[2]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Release strobes, then everything idles and acks float
	task automatic idle;
		@(posedge clk_in);
		as_n <= 1;
		ds_n <= 1;
		repeat (8) @(posedge clk_in);
		#1 chk(dec, 8'hff);
		chk({5'h00, ao}, 8'h00);
		chk({5'h1f, line}, 8'hff);
	endtask
	task automatic cyc(input logic [17:0] a, input logic r, input logic [1:0] g);
		logic [7:0] e;
		e = expect_dec(a, r, g);
		@(posedge clk_in);
		addr <= a;
		rw <= r;
		grant <= g;
		as_n <= 0;
		ds_n <= 0;
		repeat (5) @(posedge clk_in);
		#1 chk(dec, e);
		chk({7'h7f, line[2]}, {7'h7f, e[6]});
		idle;
	endtask
	task automatic test_pages;
		cyc(18'h0_0000, 1, 0);
		cyc(18'h1_8000, 1, 0);
		cyc(18'h1_bff0, 0, 0);
		cyc(18'h1_c001, 1, 0);
		$display("test_pages done");
	endtask
	task automatic test_int;
		cyc(18'h3_fff4, 1, 0);
		cyc(18'h3_fff8, 1, 0);
		cyc(18'h2_0004, 1, 0);
		$display("test_int done");
	endtask
	task automatic test_ram;
		cyc(18'h1_0000, 0, 0);
		cyc(18'h1_4000, 1, 0);
		cyc(18'h0_2000, 0, 1);
		cyc(18'h0_2000, 1, 2);
		cyc(18'h1_2000, 1, 3);
		$display("test_ram done");
	endtask
	task automatic test_ack;
		int n, d;
		n = 0;
		d = 0;
		@(posedge clk_in);
		addr <= 18'h0_0100;
		rw <= 1;
		grant <= 0;
		as_n <= 0;
		for (int k = 1; k < 12; k++) begin
			@(posedge clk_in);
			#1;
			if (line[0] === 1'b0 && n == 0) n = k;
			if (line[1] === 1'b0 && d == 0) d = k;
		end
		chk(8'(n), 8'h05);
		chk(8'(d - n), 8'h01);
		idle;
		$display("test_ack done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		srst_in <= 0;
		repeat (3) @(posedge clk_in);
		test_pages;
		test_int;
		test_ram;
		test_ack;
		stop_test;
	end
	// Watchdog: about ten times the expected run
	initial begin
		repeat (2000) @(posedge clk_in);
		mismatches++;
		stop_test;
	end
endmodule
